/* File: ris_top.v */
// Interrupt status block of the reader front end: three read-to-clear
// status registers, three mask registers, FIFO unread-byte count and
// one interrupt request line.
// Assumes event inputs are one-cycle pulses from logic on the same clock,
// except osc_stable, which comes from the analog oscillator and is synchronised.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "ris_defs.vh"

module ris_top #(
   parameter [6:0] RX_HIGH_LEVEL = 7'h40,
   parameter [6:0] TX_LOW_LEVEL = 7'h20,
   parameter GUARD_CYCLES = `RIS_GUARD_CYCLES
) (
   input wire clock,
   input wire reset,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   // Device control and events
   input wire set_defaults,
   input wire osc_enable,
   input wire osc_stable,
   input wire rx_active,
   input wire tx_active,
   input wire [6:0] fifo_unread,
   input wire rx_start,
   input wire rx_end,
   input wire tx_end,
   input wire bit_collision,
   input wire cmd_done,
   input wire no_resp_expired,
   input wire gp_timer_expired,
   input wire ext_field_on,
   input wire ext_field_off,
   input wire ca_done,
   input wire ca_field_seen,
   input wire bitrate_found,
   input wire crc_error,
   input wire parity_error,
   input wire soft_framing_error,
   input wire hard_framing_error,
   input wire wake_timeout,
   input wire wake_irq_every,
   input wire meas_valid,
   input wire [1:0] meas_kind,
   input wire [7:0] meas_value,
   input wire [7:0] meas_reference,
   input wire [7:0] meas_delta,
   // Outputs
   output reg field_on,
   output reg irq
);
   reg [7:0] mask_main;
   reg [7:0] mask_timer;
   reg [7:0] mask_error;
   reg [6:0] fifo_fill_count;
   reg [6:0] fifo_count_prev;
   reg osc_sync_1;
   reg osc_sync_2;
   reg osc_prev;
   reg guard_busy;
   reg [15:0] guard_count;
   reg [7:0] next_rdata;
   reg [7:0] main_set;
   reg [7:0] timer_set;
   reg [7:0] error_set;
   reg [7:0] main_clr;
   reg [7:0] timer_clr;
   reg [7:0] error_clr;
   reg meas_over;
   reg [6:0] next_count;
   wire [7:0] main_flags;
   wire [7:0] timer_field_irq_status;
   wire [7:0] error_wake_irq_status;
   wire [7:0] main_irq_status;
   wire read_main;
   wire read_timer;
   wire read_error;
   wire guard_done;
   wire fifo_level_flag;
   wire soft_framing_flag;
   wire hard_framing_flag;
   wire wake_timeout_flag;
   wire unread_count_msb;
   wire unread_count_lsb;
   wire [15:0] guard_last;

   // Absolute difference between a measurement and its reference
   function [7:0] ris_abs_diff;
      input [7:0] a;
      input [7:0] b;
      begin
         ris_abs_diff = (a > b) ? (a - b) : (b - a);
      end
   endfunction

   // Address match qualified by the read strobe
   function ris_hit;
      input rd;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         ris_hit = rd && (addr == ofs);
      end
   endfunction

   assign read_main = ris_hit(reg_read, reg_addr, `RIS_OFS_MAIN);
   assign read_timer = ris_hit(reg_read, reg_addr, `RIS_OFS_TIMER);
   assign read_error = ris_hit(reg_read, reg_addr, `RIS_OFS_ERROR);
   // Last count value, cut to the counter width on purpose
   localparam [31:0] GUARD_SPAN = GUARD_CYCLES - 1;
   assign guard_last = GUARD_SPAN[15:0];
   assign guard_done = guard_busy && (guard_count == guard_last);

   // Oscillator ready comes from the analog side, so two flops first
   always @(posedge clock) begin
      if (reset) begin
         osc_sync_1 <= 1'b0;
         osc_sync_2 <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_sync_1 <= osc_stable;
         osc_sync_2 <= osc_sync_1;
         osc_prev <= osc_sync_2;
      end
   end

   // Mask registers; writes ignore the unused low bits of the main mask
   always @(posedge clock) begin
      if (reset || set_defaults) begin
         mask_main <= `RIS_RST_MASK;
         mask_timer <= `RIS_RST_MASK;
         mask_error <= `RIS_RST_MASK;
      end else if (reg_write) begin
         if (reg_addr == `RIS_OFS_MASK_MAIN) begin
            mask_main <= reg_wdata & `RIS_MAIN_RC_MASK;
         end
         if (reg_addr == `RIS_OFS_MASK_TIMER) begin
            mask_timer <= reg_wdata;
         end
         if (reg_addr == `RIS_OFS_MASK_ERROR) begin
            mask_error <= reg_wdata;
         end
      end
   end

   // Unread byte count, held within the FIFO size
   always @* begin
      next_count = fifo_unread;
      if (fifo_unread > `RIS_FIFO_BYTES) begin
         next_count = `RIS_FIFO_BYTES;
      end
   end

   always @(posedge clock) begin
      if (reset || set_defaults) begin
         fifo_fill_count <= `RIS_RST_COUNT;
         fifo_count_prev <= `RIS_RST_COUNT;
      end else begin
         fifo_fill_count <= next_count;
         fifo_count_prev <= fifo_fill_count;
      end
   end

   assign unread_count_msb = fifo_fill_count[6];
   assign unread_count_lsb = fifo_fill_count[0];

   // Water level fires on crossing the threshold, not while parked there,
   // so one burst of FIFO traffic gives one request
   assign fifo_level_flag =
      (rx_active && (fifo_fill_count >= RX_HIGH_LEVEL) && (fifo_count_prev < RX_HIGH_LEVEL)) ||
      (tx_active && (fifo_fill_count <= TX_LOW_LEVEL) && (fifo_count_prev > TX_LOW_LEVEL));

   // Guard timer after collision avoidance found a quiet air gap
   always @(posedge clock) begin
      if (reset || set_defaults) begin
         guard_busy <= 1'b0;
         guard_count <= 16'h0000;
         field_on <= 1'b0;
      end else begin
         if (ca_done && !ca_field_seen) begin
            field_on <= 1'b1;
            guard_busy <= 1'b1;
            guard_count <= 16'h0000;
         end else if (guard_done) begin
            guard_busy <= 1'b0;
         end else if (guard_busy) begin
            guard_count <= guard_count + 16'h0001;
         end
      end
   end

   // Measurement outside its window, compared against the delta
   always @* begin
      meas_over = meas_valid && (ris_abs_diff(meas_value, meas_reference) > meas_delta);
   end

   assign soft_framing_flag = soft_framing_error;
   assign hard_framing_flag = hard_framing_error;
   assign wake_timeout_flag = wake_timeout && wake_irq_every;

   // Event set vectors
   always @* begin
      main_set = 8'h00;
      main_set[`RIS_MAIN_OSC] = osc_enable && osc_sync_2 && !osc_prev;
      main_set[`RIS_MAIN_WL] = fifo_level_flag;
      main_set[`RIS_MAIN_RXS] = rx_start;
      main_set[`RIS_MAIN_RXE] = rx_end;
      main_set[`RIS_MAIN_TXE] = tx_end;
      main_set[`RIS_MAIN_COL] = bit_collision;

      timer_set = 8'h00;
      timer_set[`RIS_TIM_DCT] = cmd_done;
      timer_set[`RIS_TIM_NRE] = no_resp_expired;
      timer_set[`RIS_TIM_GPE] = gp_timer_expired;
      timer_set[`RIS_TIM_EON] = ext_field_on;
      timer_set[`RIS_TIM_EOF] = ext_field_off;
      timer_set[`RIS_TIM_CAC] = ca_done && ca_field_seen;
      timer_set[`RIS_TIM_CAT] = guard_done;
      timer_set[`RIS_TIM_NFCT] = bitrate_found;

      error_set = 8'h00;
      error_set[`RIS_ERR_CRC] = crc_error;
      error_set[`RIS_ERR_PAR] = parity_error;
      error_set[`RIS_ERR_SOFT] = soft_framing_flag;
      error_set[`RIS_ERR_HARD] = hard_framing_flag;
      error_set[`RIS_ERR_WT] = wake_timeout_flag;
      error_set[`RIS_ERR_WAM] = meas_over && (meas_kind == `RIS_MEAS_AMP);
      error_set[`RIS_ERR_WPH] = meas_over && (meas_kind == `RIS_MEAS_PHASE);
      error_set[`RIS_ERR_WCAP] = meas_over && (meas_kind == `RIS_MEAS_CAP);
   end

   // Clear vectors; a main read wipes the detail registers too, which
   // also drops main bits 1 and 0 since they mirror the details
   always @* begin
      main_clr = read_main ? `RIS_MAIN_RC_MASK : 8'h00;
      timer_clr = (read_main || read_timer) ? 8'hff : 8'h00;
      error_clr = (read_main || read_error) ? 8'hff : 8'h00;
   end

   // Flag banks; set beats clear inside the bank
   ris_flag_reg #(
      .WIDTH(8)
   ) u_main_flags (
      .clock(clock),
      .reset(reset),
      .clear_all(set_defaults),
      .set_vec(main_set),
      .clr_vec(main_clr),
      .flags(main_flags)
   );

   ris_flag_reg #(
      .WIDTH(8)
   ) u_timer_flags (
      .clock(clock),
      .reset(reset),
      .clear_all(set_defaults),
      .set_vec(timer_set),
      .clr_vec(timer_clr),
      .flags(timer_field_irq_status)
   );

   ris_flag_reg #(
      .WIDTH(8)
   ) u_error_flags (
      .clock(clock),
      .reset(reset),
      .clear_all(set_defaults),
      .set_vec(error_set),
      .clr_vec(error_clr),
      .flags(error_wake_irq_status)
   );

   // Summary bits are live views of the detail banks
   assign main_irq_status = {main_flags[7:2],
                             |timer_field_irq_status,
                             |error_wake_irq_status};

   // Read data mux; unmapped addresses read zero
   always @* begin
      case (reg_addr)
         `RIS_OFS_MASK_MAIN: next_rdata = mask_main;
         `RIS_OFS_MASK_TIMER: next_rdata = mask_timer;
         `RIS_OFS_MASK_ERROR: next_rdata = mask_error;
         `RIS_OFS_MAIN: next_rdata = main_irq_status;
         `RIS_OFS_TIMER: next_rdata = timer_field_irq_status;
         `RIS_OFS_ERROR: next_rdata = error_wake_irq_status;
         `RIS_OFS_FIFO: next_rdata = {1'b0, unread_count_msb, fifo_fill_count[5:1], unread_count_lsb};
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Request line, one cycle behind the flags it summarises
   always @(posedge clock) begin
      if (reset || set_defaults) begin
         irq <= 1'b0;
      end else begin
         irq <= (|(main_flags & ~mask_main & `RIS_MAIN_RC_MASK)) ||
                (|(timer_field_irq_status & ~mask_timer)) ||
                (|(error_wake_irq_status & ~mask_error));
      end
   end
endmodule // ris_top

/* File: ris_defs.vh */
// Register map, field positions, reset values and timing counts of the
// reader interrupt status block.
// Assumes the includer has a clock at the rate given below.
`ifndef RIS_DEFS_VH
`define RIS_DEFS_VH

// Register offsets
`define RIS_OFS_MASK_MAIN 8'h14
`define RIS_OFS_MASK_TIMER 8'h15
`define RIS_OFS_MASK_ERROR 8'h16
`define RIS_OFS_MAIN 8'h17
`define RIS_OFS_TIMER 8'h18
`define RIS_OFS_ERROR 8'h19
`define RIS_OFS_FIFO 8'h1a

// Reset values
`define RIS_RST_FLAGS 8'h00
`define RIS_RST_MASK 8'h00
`define RIS_RST_COUNT 7'h00

// Main status fields
`define RIS_MAIN_OSC 7
`define RIS_MAIN_WL 6
`define RIS_MAIN_RXS 5
`define RIS_MAIN_RXE 4
`define RIS_MAIN_TXE 3
`define RIS_MAIN_COL 2
`define RIS_MAIN_TIM 1
`define RIS_MAIN_ERR 0
// Bits that a read of the main register clears directly
`define RIS_MAIN_RC_MASK 8'hfc

// Timer and field detail fields
`define RIS_TIM_DCT 7
`define RIS_TIM_NRE 6
`define RIS_TIM_GPE 5
`define RIS_TIM_EON 4
`define RIS_TIM_EOF 3
`define RIS_TIM_CAC 2
`define RIS_TIM_CAT 1
`define RIS_TIM_NFCT 0

// Error and wake-up detail fields
`define RIS_ERR_CRC 7
`define RIS_ERR_PAR 6
`define RIS_ERR_SOFT 5
`define RIS_ERR_HARD 4
`define RIS_ERR_WT 3
`define RIS_ERR_WAM 2
`define RIS_ERR_WPH 1
`define RIS_ERR_WCAP 0

// Measurement kinds
`define RIS_MEAS_AMP 2'h0
`define RIS_MEAS_PHASE 2'h1
`define RIS_MEAS_CAP 2'h2

// FIFO size and clock timing
`define RIS_FIFO_BYTES 7'h60
`define RIS_CLOCK_NS 8
`define RIS_GUARD_TIME_NS 5000
`define RIS_GUARD_CYCLES ((`RIS_GUARD_TIME_NS + `RIS_CLOCK_NS - 1) / `RIS_CLOCK_NS)

`endif

/* File: ris_flag_reg.v */
// Bank of sticky event flags with a per-bit clear vector.
// Assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ps
module ris_flag_reg #(
   parameter WIDTH = 8
) (
   input wire clock,
   input wire reset,
   input wire clear_all,
   input wire [WIDTH-1:0] set_vec,
   input wire [WIDTH-1:0] clr_vec,
   output wire [WIDTH-1:0] flags
);
   reg [WIDTH-1:0] flag_q;
   genvar i;

   // One flop per flag; a new event beats a clearing read in the same cycle
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
         always @(posedge clock) begin
            if (reset || clear_all) begin
               flag_q[i] <= 1'b0;
            end else if (set_vec[i]) begin
               flag_q[i] <= 1'b1;
            end else if (clr_vec[i]) begin
               flag_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flag_q;
endmodule // ris_flag_reg

/* File: ris_host.sv */
// Host model: register port master of the interrupt status block.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
module ris_host (
   input wire clock,
   output reg [7:0] reg_addr,
   output reg [7:0] reg_wdata,
   output reg reg_write,
   output reg reg_read,
   input wire [7:0] reg_rdata
);
   // Bus idle from time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // One-cycle write strobe
   task wr(input [7:0] a, input [7:0] v);
      begin
         reg_addr <= a;
         reg_wdata <= v;
         reg_write <= 1'b1;
         @(posedge clock);
         reg_write <= 1'b0;
      end
   endtask
   // Data stands only the cycle after the strobe, so it is taken at that edge
   task rd(input [7:0] a, output [7:0] v);
      begin
         reg_addr <= a;
         reg_read <= 1'b1;
         @(posedge clock);
         reg_read <= 1'b0;
         @(posedge clock);
         v = reg_rdata;
      end
   endtask
endmodule // ris_host

/* File: ris_assertions.sv */
// Checker of the interrupt status block, bound to ris_top.
// Assumes event pins pulse for one cycle and masks change only by writes.
`timescale 1ns/1ps
module ris_checker (
   input wire clock,
   input wire reset,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_rdata,
   input wire set_defaults,
   input wire rx_end,
   input wire crc_error,
   input wire ca_done,
   input wire ca_field_seen,
   input wire field_on,
   input wire irq
);
   reg [7:0] m_main;
   reg [7:0] m_err;
   // Shadow masks; the two low main mask bits never hold a one
   always @(posedge clock) begin
      if (reset || set_defaults) begin
         m_main <= 8'h00;
         m_err <= 8'h00;
      end else if (reg_write && reg_addr == 8'h14) begin
         m_main <= reg_wdata & 8'hfc;
      end else if (reg_write && reg_addr == 8'h16) begin
         m_err <= reg_wdata;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // Unmasked event with no mask write or defaults disturbing it
   sequence s_hit(ev, m);
      ev && !m && !reg_write && !set_defaults ##1 !set_defaults;
   endsequence
   sequence s_main_rd;
      reg_read && reg_addr == 8'h17 && !rx_end && !crc_error;
   endsequence
   property p_mask_rd;
      reg_read && reg_addr == 8'h14 && !set_defaults |=> reg_rdata == m_main;
   endproperty
   a_mask_rd: assert property (p_mask_rd) else $error("main mask read back wrong");
   property p_fifo_rd;
      reg_read && reg_addr == 8'h1a |=> !reg_rdata[7] && reg_rdata <= 8'h60;
   endproperty
   a_fifo_rd: assert property (p_fifo_rd) else $error("unread count out of range");
   property p_rxe_irq;
      s_hit(rx_end, m_main[4]) |=> irq;
   endproperty
   a_rxe_irq: assert property (p_rxe_irq) else $error("no request after end of receive");
   property p_crc_irq;
      s_hit(crc_error, m_err[7]) |=> irq;
   endproperty
   a_crc_irq: assert property (p_crc_irq) else $error("no request after crc error");
   property p_set_wins;
      s_hit(crc_error && reg_read && reg_addr == 8'h17, m_err[7]) |=> irq;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost under clearing read");
   property p_main_clr;
      s_main_rd |=> ##1 !irq;
   endproperty
   a_main_clr: assert property (p_main_clr) else $error("request stays after main read");
   property p_dflt;
      set_defaults |=> !irq && !field_on;
   endproperty
   a_dflt: assert property (p_dflt) else $error("defaults left request or field");
   property p_field_set;
      (field_on || ca_done && !ca_field_seen) && !set_defaults |=> field_on;
   endproperty
   a_field_set: assert property (p_field_set) else $error("own field not on");
   property p_field_quiet;
      !field_on && !(ca_done && !ca_field_seen) |=> !field_on;
   endproperty
   a_field_quiet: assert property (p_field_quiet) else $error("own field on without cause");
endmodule // ris_checker

/* File: ris_top_tb.sv */
// Testbench of the interrupt status block: host model plus event pulses.
// Assumes a guard count of 4 cycles and a 125 MHz clock.
`timescale 1ns/1ps
module ris_top_tb;
   localparam G = 4;
   localparam [23:0] VAL = {8'hf8, 8'hf9, 8'h3c};
   reg clock = 1'b0;
   reg reset = 1'b1;
   reg set_defaults = 1'b0, osc_enable = 1'b0, osc_stable = 1'b0, rx_active = 1'b0, tx_active = 1'b0;
   reg ca_done = 1'b0, ca_field_seen = 1'b0, wake_irq_every = 1'b1, meas_valid = 1'b0;
   reg [1:0] meas_kind = 2'h0;
   reg [6:0] fifo_unread = 7'h00;
   reg [7:0] meas_value = 8'h00, meas_reference = 8'h40, meas_delta = 8'h10, pm = 8'h00, pt = 8'h00, pe = 8'h00, d, p;
   wire [7:0] reg_addr, reg_wdata, reg_rdata;
   wire reg_write, reg_read, field_on, irq;
   wire rx_start = pm[5], rx_end = pm[4], tx_end = pm[3], bit_collision = pm[2];
   wire cmd_done = pt[7], no_resp_expired = pt[6], gp_timer_expired = pt[5], ext_field_on = pt[4];
   wire ext_field_off = pt[3], bitrate_found = pt[0], wake_timeout = pe[3];
   wire crc_error = pe[7], parity_error = pe[6], soft_framing_error = pe[5], hard_framing_error = pe[4];
   integer n_errors = 0, check_count = 0, r, b;
   ris_top #(.GUARD_CYCLES(G)) dut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .set_defaults, .osc_enable, .osc_stable, .rx_active, .tx_active, .fifo_unread, .rx_start, .rx_end, .tx_end,
      .bit_collision, .cmd_done, .no_resp_expired, .gp_timer_expired, .ext_field_on, .ext_field_off, .ca_done,
      .ca_field_seen, .bitrate_found, .crc_error, .parity_error, .soft_framing_error, .hard_framing_error,
      .wake_timeout, .wake_irq_every, .meas_valid, .meas_kind, .meas_value, .meas_reference, .meas_delta,
      .field_on, .irq);
   ris_host host (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
   // Free-running clock
   initial begin
      forever #4 clock = ~clock;
   end
   task chk(input [7:0] got, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rc(input [7:0] a, input [7:0] exp);
      begin
         host.rd(a, d);
         chk(d, exp);
      end
   endtask
   // One-cycle event on main (0), timer (1) or error (2) pins
   task pulse(input integer k, input [7:0] v);
      begin
         pm <= (k == 0) ? v : 8'h00;
         pt <= (k == 1) ? v : 8'h00;
         pe <= (k == 2) ? v : 8'h00;
         @(posedge clock);
         pm <= 8'h00;
         pt <= 8'h00;
         pe <= 8'h00;
         @(posedge clock);
      end
   endtask
   task close_out;
      begin
         $display("errors %0d checks %0d", n_errors, check_count);
         if (n_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge clock);
      n_errors = n_errors + 1;
      close_out;
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      for (r = 8'h14; r <= 8'h1b; r = r + 1)
         rc(r[7:0], 8'h00);
      // Each pin-driven flag alone; the main read zeroes the detail registers too
      for (r = 0; r < 3; r = r + 1)
         for (b = 0; b < 8; b = b + 1)
            if (VAL[r * 8 + b]) begin
               p = 8'h01 << b;
               pulse(r, p);
               rc(8'h17, r == 0 ? p : 8'h04 >> r);
               rc(8'h17, 8'h00);
               if (r > 0) begin
                  rc(8'h17 + r[7:0], 8'h00);
                  pulse(r, p);
                  rc(8'h17 + r[7:0], p);
                  rc(8'h17 + r[7:0], 8'h00);
                  rc(8'h17, 8'h00);
               end
            end
      wake_irq_every <= 1'b0;
      pulse(2, 8'h08);
      rc(8'h19, 8'h00);
      // Difference equal to delta must not flag, one more must; kind 3 never flags
      for (r = 0; r < 4; r = r + 1) begin
         meas_kind <= r[1:0];
         meas_value <= 8'h50;
         meas_valid <= 1'b1;
         @(posedge clock);
         meas_value <= 8'h51;
         @(posedge clock);
         meas_valid <= 1'b0;
         rc(8'h19, 8'h04 >> r);
      end
      ca_field_seen <= 1'b1;
      ca_done <= 1'b1;
      @(posedge clock);
      ca_done <= 1'b0;
      @(posedge clock);
      rc(8'h18, 8'h04);
      chk({7'h00, field_on}, 8'h00);
      ca_field_seen <= 1'b0;
      ca_done <= 1'b1;
      @(posedge clock);
      ca_done <= 1'b0;
      // First read is taken at the edge the guard flag sets: it sees zero, and the set beats its clear
      repeat (G - 1) @(posedge clock);
      rc(8'h18, 8'h00);
      rc(8'h18, 8'h02);
      chk({7'h00, field_on}, 8'h01);
      rx_active <= 1'b1;
      fifo_unread <= 7'h46;
      repeat (3) @(posedge clock);
      rc(8'h1a, 8'h46);
      rc(8'h17, 8'h40);
      rx_active <= 1'b0;
      tx_active <= 1'b1;
      fifo_unread <= 7'h0a;
      repeat (3) @(posedge clock);
      rc(8'h17, 8'h40);
      fifo_unread <= 7'h60; // Host refills the buffer
      repeat (2) @(posedge clock);
      rc(8'h1a, 8'h60);
      fifo_unread <= 7'h7f;
      repeat (2) @(posedge clock);
      rc(8'h1a, 8'h60);
      fifo_unread <= 7'h00;
      tx_active <= 1'b0;
      host.wr(8'h14, 8'hff);
      rc(8'h14, 8'hfc);
      pulse(0, 8'h10);
      chk({7'h00, irq}, 8'h00);
      host.wr(8'h14, 8'h00);
      repeat (2) @(posedge clock);
      chk({7'h00, irq}, 8'h01);
      rc(8'h17, 8'h10);
      @(posedge clock);
      chk({7'h00, irq}, 8'h00);
      host.wr(8'h16, 8'hff);
      rc(8'h16, 8'hff);
      pulse(2, 8'h80);
      chk({7'h00, irq}, 8'h00);
      host.wr(8'h16, 8'h00);
      repeat (2) @(posedge clock);
      chk({7'h00, irq}, 8'h01);
      rc(8'h19, 8'h80);
      @(posedge clock);
      chk({7'h00, irq}, 8'h00);
      // Error event lands in the very cycle of a clearing main read
      pulse(1, 8'h80);
      pe <= 8'h80;
      fork
         host.rd(8'h17, d);
         begin
            @(posedge clock);
            pe <= 8'h00;
         end
      join
      chk(d, 8'h02);
      rc(8'h19, 8'h80);
      rc(8'h18, 8'h00);
      host.wr(8'h15, 8'hf0);
      pulse(0, 8'h20);
      set_defaults <= 1'b1;
      @(posedge clock);
      set_defaults <= 1'b0;
      rc(8'h17, 8'h00);
      rc(8'h15, 8'h00);
      chk({6'h00, field_on, irq}, 8'h00);
      // Oscillator settling without the enable bit must not flag
      osc_stable <= 1'b1;
      repeat (4) @(posedge clock);
      rc(8'h17, 8'h00);
      osc_stable <= 1'b0;
      repeat (3) @(posedge clock);
      osc_enable <= 1'b1;
      osc_stable <= 1'b1;
      repeat (4) @(posedge clock);
      rc(8'h17, 8'h80);
      close_out;
   end
endmodule // ris_top_tb
bind ris_top ris_checker chk_i (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
   .set_defaults, .rx_end, .crc_error, .ca_done, .ca_field_seen, .field_on, .irq);
